// [adcsc_pkg.sv]
// Shared constants and types for the converter serial setup and readout port
package adcsc_pkg;

  // Word widths
  localparam int CFG_WIDTH    = 14;      // Setup word length in bits
  localparam int RESULT_WIDTH = 16;      // Conversion result length in bits
  localparam int CHAN_COUNT   = 8;       // Analog inputs behind the mux
  localparam int CNT_WIDTH    = 5;       // Edge counters reach 31

  // Setup word field positions
  localparam int UPDATE_BIT   = 13;      // Update flag
  localparam int INCFG_MSB    = 12;      // Input configuration field
  localparam int INCFG_LSB    = 10;
  localparam int CHAN_MSB     = 9;       // Channel select field
  localparam int CHAN_LSB     = 7;
  localparam int BW_BIT       = 6;       // Filter bandwidth bit
  localparam int REF_MSB      = 5;       // Reference field
  localparam int REF_LSB      = 3;
  localparam int SEQ_MSB      = 2;       // Sequencer field
  localparam int SEQ_LSB      = 1;
  localparam int READBACK_BIT = 0;       // Readback enable bit

  // Default and reset setup word (all ones)
  localparam logic [13:0] CFG_DEFAULT = 14'h3FFF;
  localparam logic [13:0] CFG_RESET   = 14'h3FFF;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Serial edge counts
  localparam logic [4:0] CFG_RISE_EDGES   = 5'h0E;   // 14 capture edges
  localparam logic [4:0] RESULT_BITS      = 5'h10;   // 16 result bits
  localparam logic [4:0] BUSY_EXTRA_BITS  = 5'h01;   // Leading busy bit
  localparam logic [4:0] READBACK_BITS    = 5'h0E;   // 14 readback bits
  localparam logic [1:0] DEFAULT_CONVS    = 2'h2;    // Conversions w/ DIN high

  // Stream vector width: busy bit, result, readback
  localparam int STREAM_WIDTH = 31;

  // Conversion tracking states
  typedef enum logic [1:0] {
    ADCSC_IDLE     = 2'b00,
    ADCSC_CONVERT  = 2'b01,
    ADCSC_FINISH   = 2'b10
  } adcsc_conv_state_t;

endpackage : adcsc_pkg

// [adcsc_sync.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module adcsc_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;   // Metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2;   // Second stage
  logic [WIDTH-1:0] stage3;   // Third stage

  // Elaboration check: a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("adcsc_sync: WIDTH must be at least 1");
  end

  // Per bit: accept a new level only when two stages agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stage1[i]   <= INIT[i];
        stage2[i]   <= INIT[i];
        stage3[i]   <= INIT[i];
        sync_out[i] <= INIT[i];
      end else begin
        stage1[i] <= async_in[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];   // Filter out one-stage glitches
        end
      end
    end
  end

endmodule : adcsc_sync

// [adcsc_top.sv]
// Serial setup and readout port of an eight-channel sampling converter
`timescale 1ns/10ps
// Notes on behaviour
// - Setup word captured MSB first, 14 rising edges
// - Result out on 15 falls, 16 busy
// - Readback adds 14 falls after result LSB
// - Trigger rise starts conversion; access while low
// - Access in conversion n: result n-1
// - New setup applied at end of conversion
// - Host runs two dummy conversions after power-up
// - Input high two conversions loads all ones
// - All-ones default scans all eight inputs
// - Setup word field layout fixed
// - Capture depends only on serial clock edges and the trigger pin
// - Update flag zero keeps present configuration
// - Channel field is plain binary input number
module adcsc_top (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          SERIAL_CLOCK,
  input  wire logic                          CONVERSION_TRIGGER,
  input  wire logic                          SERIAL_CONFIG_IN,
  output logic                               SERIAL_RESULT_OUT,
  output logic                               SERIAL_RESULT_OE,
  input  wire logic                          BUSY_INDICATION_MODE,
  output logic                               CONV_START,
  input  wire logic                          CONV_DONE,
  input  wire logic [adcsc_pkg::RESULT_WIDTH-1:0] CONV_RESULT,
  output logic      [adcsc_pkg::CFG_WIDTH-1:0]    ACTIVE_CONFIG,
  output logic      [2:0]                    INPUT_CONFIG_FIELD,
  output logic      [2:0]                    CHANNEL_SELECT_FIELD,
  output logic      [adcsc_pkg::CHAN_COUNT-1:0]   CHANNEL_ENABLE,
  output logic                               FILTER_BANDWIDTH_BIT,
  output logic      [2:0]                    REFERENCE_FIELD,
  output logic      [1:0]                    SEQUENCER_FIELD,
  output logic                               READBACK_BIT,
  output logic                               CONVERTING
);
  import adcsc_pkg::*;

  // ------------------------------------------------------------------
  // Link domain: setup word capture on rising serial clock edges
  // ------------------------------------------------------------------
  logic [CNT_WIDTH-1:0] rise_count;     // Rising edges seen this frame
  logic [CFG_WIDTH-1:0] capture_shift;  // Bits gathered so far
  logic [CFG_WIDTH-1:0] captured_word;  // Last complete setup word
  logic                 capture_toggle; // Flips once per complete word
  wire                  last_capture;   // This edge completes the word
  wire                  capture_open;   // Still inside the first 14 edges

  assign capture_open = (rise_count < CFG_RISE_EDGES);
  assign last_capture = (rise_count == CFG_RISE_EDGES - 5'h01);

  // Counter and shifter are cleared by the trigger pin itself, so a
  // frame ends even though the serial clock stops between frames
  always_ff @(posedge SERIAL_CLOCK or posedge CONVERSION_TRIGGER
              or posedge RST) begin
    if (RST || CONVERSION_TRIGGER) begin
      rise_count    <= '0;
      capture_shift <= '0;
    end else if (capture_open) begin
      rise_count    <= rise_count + 5'h01;
      capture_shift <= {capture_shift[CFG_WIDTH-2:0],
                        SERIAL_CONFIG_IN};
    end
  end

  // Complete word is held until the next complete word; the toggle
  // tells the system domain that a new one stands ready
  always_ff @(posedge SERIAL_CLOCK or posedge RST) begin
    if (RST) begin
      captured_word  <= CFG_RESET;
      capture_toggle <= 1'b0;
    end else if (!CONVERSION_TRIGGER && last_capture) begin
      captured_word  <= {capture_shift[CFG_WIDTH-2:0],
                         SERIAL_CONFIG_IN};
      capture_toggle <= ~capture_toggle;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: result stream on falling serial clock edges
  // ------------------------------------------------------------------
  logic [CNT_WIDTH-1:0]    fall_count;   // Falling edges seen this frame
  logic [RESULT_WIDTH-1:0] out_result;   // Result published for readout
  logic [CFG_WIDTH-1:0]    out_config;   // Setup word tied to that result
  logic                    out_readback; // Readback enable for the frame
  wire  [STREAM_WIDTH-1:0] stream_word;  // Bits in shift-out order
  wire  [CNT_WIDTH-1:0]    stream_len;   // Bits to shift this frame
  wire  [CNT_WIDTH-1:0]    bit_index;    // Vector index of current bit
  wire                     stream_bit;   // Current bit or idle zero

  // Busy mode puts one leading indicator bit ahead of the result
  assign stream_word = BUSY_INDICATION_MODE
                     ? {1'b0, out_result, out_config}
                     : {out_result, out_config, 1'b0};
  assign stream_len  = RESULT_BITS
                     + (BUSY_INDICATION_MODE ? BUSY_EXTRA_BITS : 5'h00)
                     + (out_readback ? READBACK_BITS : 5'h00);
  assign bit_index   = 5'h1E - fall_count;
  assign stream_bit  = (fall_count < stream_len) ? stream_word[bit_index]
                                                 : 1'b0;

  // First bit is shown when the trigger falls; each falling edge then
  // advances one bit, so 15 edges finish a 16-bit result, 16 in busy mode
  always_ff @(negedge SERIAL_CLOCK or posedge CONVERSION_TRIGGER
              or posedge RST) begin
    if (RST || CONVERSION_TRIGGER) begin
      fall_count <= '0;
    end else if (fall_count < stream_len) begin
      fall_count <= fall_count + 5'h01;
    end
  end

  // Output drives only while the trigger pin selects the device
  assign SERIAL_RESULT_OE  = ~CONVERSION_TRIGGER;
  assign SERIAL_RESULT_OUT = SERIAL_RESULT_OE & stream_bit;

  // ------------------------------------------------------------------
  // System domain: synchronise pins and the capture toggle
  // ------------------------------------------------------------------
  logic trigger_sync;     // Trigger level in system domain
  logic config_in_sync;   // Serial data level in system domain
  logic toggle_sync;      // Capture toggle in system domain
  logic trigger_prev;     // Trigger one cycle ago
  logic toggle_prev;      // Toggle one cycle ago
  wire  trigger_rise;     // Start of a conversion
  wire  trigger_fall;     // Start of a serial frame
  wire  new_word;         // A setup word has been captured

  adcsc_sync #(
    .WIDTH (3),
    .INIT  (3'b100)
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .async_in ({CONVERSION_TRIGGER, SERIAL_CONFIG_IN, capture_toggle}),
    .sync_out ({trigger_sync, config_in_sync, toggle_sync})
  );

  assign trigger_rise = trigger_sync & ~trigger_prev;
  assign trigger_fall = ~trigger_sync & trigger_prev;
  assign new_word     = toggle_sync ^ toggle_prev;

  // Edge history for the synchronised levels
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trigger_prev <= 1'b1;
      toggle_prev  <= 1'b0;
    end else begin
      trigger_prev <= trigger_sync;
      toggle_prev  <= toggle_sync;
    end
  end

  // ------------------------------------------------------------------
  // System domain: conversion tracking
  // ------------------------------------------------------------------
  adcsc_conv_state_t state;        // Conversion phase
  adcsc_conv_state_t next_state;   // Phase for the next cycle
  logic              result_pend;  // Finished result not yet published
  logic [RESULT_WIDTH-1:0] held_result;  // Result waiting for publish
  logic [CFG_WIDTH-1:0]    held_config;  // Its setup word
  logic [CFG_WIDTH-1:0]    conv_config;  // Setup word of running conversion
  wire               finish;       // Conversion has just ended
  wire               can_publish;  // No frame can be reading now

  assign finish      = (state == ADCSC_CONVERT) && CONV_DONE;
  // Publish only on a synchronised rise: the pin is then surely still
  // high, whereas the synchronised level lags the pin's fall by cycles
  assign can_publish = trigger_rise;

  // Next-phase decode
  always_comb begin
    next_state = state;
    case (state)
      ADCSC_IDLE: begin
        if (trigger_rise) next_state = ADCSC_CONVERT;
      end
      ADCSC_CONVERT: begin
        if (CONV_DONE) next_state = ADCSC_FINISH;
      end
      ADCSC_FINISH: begin
        next_state = ADCSC_IDLE;   // One cycle to apply new setup
      end
      default: begin
        next_state = ADCSC_IDLE;
      end
    endcase
  end

  // Phase register and start pulse toward the converter core
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state      <= ADCSC_IDLE;
      CONV_START <= 1'b0;
    end else begin
      state      <= next_state;
      CONV_START <= (state == ADCSC_IDLE) && trigger_rise;
    end
  end

  assign CONVERTING = (state != ADCSC_IDLE);

  // Result publishing. A frame reads the published words straight
  // across the clock boundary, so they only change while the trigger
  // is high; every finished result waits for the next
  // trigger rise, which keeps readout one conversion behind.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      held_result  <= RESULT_RESET;
      held_config  <= CFG_RESET;
      result_pend  <= 1'b0;
      out_result   <= RESULT_RESET;
      out_config   <= CFG_RESET;
      out_readback <= 1'b0;
    end else begin
      if (finish) begin
        held_result <= CONV_RESULT;
        held_config <= conv_config;
        result_pend <= 1'b1;
      end else if (result_pend && can_publish) begin
        out_result   <= held_result;
        out_config   <= held_config;
        // Readback bit is active low: the all-ones word has none
        out_readback <= ~ACTIVE_CONFIG[adcsc_pkg::READBACK_BIT];
        result_pend  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // System domain: setup word pipeline
  // ------------------------------------------------------------------
  logic [CFG_WIDTH-1:0] pending_config; // Word written, not yet used
  logic                 pending_valid;  // A pending word exists
  logic [1:0]           high_count;     // Conversions with input high
  logic                 high_seen;      // Input stayed high since start
  logic [2:0]           seq_channel;    // Sequencer position
  wire                  load_default;   // Default preload condition
  wire                  seq_on;         // Sequencer active
  wire  [2:0]           chan_field;     // Channel field of active word
  wire                  conv_begin;     // Rise that starts a conversion

  // Rises during a conversion are ignored, so they count for nothing
  assign conv_begin   = trigger_rise && (state == ADCSC_IDLE);
  assign load_default = (high_count == DEFAULT_CONVS - 2'h1)
                        && high_seen && conv_begin;

  // Written words wait here until the running conversion ends
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pending_config <= CFG_RESET;
      pending_valid  <= 1'b0;
    end else if (load_default) begin
      pending_config <= CFG_DEFAULT;
      pending_valid  <= 1'b1;
    end else if (new_word) begin
      pending_config <= captured_word;
      pending_valid  <= 1'b1;
    end else if (state == ADCSC_FINISH) begin
      pending_valid  <= 1'b0;
    end
  end

  // Track the serial data input held high across conversions
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      high_count <= 2'h0;
      high_seen  <= 1'b0;
    end else if (!config_in_sync) begin
      high_count <= 2'h0;
      high_seen  <= 1'b0;
    end else if (conv_begin) begin
      high_seen  <= 1'b1;
      if (high_count != DEFAULT_CONVS) begin
        high_count <= high_count + 2'h1;
      end
    end
  end

  // Active word changes only after a conversion, one stage behind the
  // write; a clear update flag keeps what is there
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ACTIVE_CONFIG <= CFG_RESET;
    end else if (state == ADCSC_FINISH && pending_valid
                 && pending_config[UPDATE_BIT]) begin
      ACTIVE_CONFIG <= pending_config;
    end
  end

  // Word that governs the conversion now starting
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      conv_config <= CFG_RESET;
    end else if (CONV_START) begin
      conv_config <= ACTIVE_CONFIG;
    end
  end

  // ------------------------------------------------------------------
  // Field decode toward the analog front end
  // ------------------------------------------------------------------
  assign INPUT_CONFIG_FIELD   = ACTIVE_CONFIG[INCFG_MSB:INCFG_LSB];
  assign chan_field           = ACTIVE_CONFIG[CHAN_MSB:CHAN_LSB];
  assign FILTER_BANDWIDTH_BIT = ACTIVE_CONFIG[BW_BIT];
  assign REFERENCE_FIELD      = ACTIVE_CONFIG[REF_MSB:REF_LSB];
  assign SEQUENCER_FIELD      = ACTIVE_CONFIG[SEQ_MSB:SEQ_LSB];
  assign READBACK_BIT         = ACTIVE_CONFIG[adcsc_pkg::READBACK_BIT];
  assign seq_on               = (SEQUENCER_FIELD != 2'b00);

  // Sequencer walks from input 0 up to the channel field, then wraps
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seq_channel <= 3'h0;
    end else if (!seq_on) begin
      seq_channel <= 3'h0;
    end else if (state == ADCSC_FINISH) begin
      if (seq_channel >= chan_field) begin
        seq_channel <= 3'h0;
      end else begin
        seq_channel <= seq_channel + 3'h1;
      end
    end
  end

  assign CHANNEL_SELECT_FIELD = seq_on ? seq_channel : chan_field;

  // One-hot input enable: value k picks input k
  genvar c;
  for (c = 0; c < CHAN_COUNT; c++) begin : g_chan
    assign CHANNEL_ENABLE[c] =
      (CHANNEL_SELECT_FIELD == 3'(c));
  end

endmodule : adcsc_top

// [adcsc_monitor.sv]
// Checker for the converter serial port, bound to the top
`timescale 1ns/10ps
module adcsc_monitor (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        SERIAL_CLOCK,
  input wire logic        CONVERSION_TRIGGER,
  input wire logic        SERIAL_CONFIG_IN,
  input wire logic        SERIAL_RESULT_OUT,
  input wire logic        SERIAL_RESULT_OE,
  input wire logic        BUSY_INDICATION_MODE,
  input wire logic        CONV_START,
  input wire logic        CONV_DONE,
  input wire logic [15:0] CONV_RESULT,
  input wire logic [13:0] ACTIVE_CONFIG,
  input wire logic [2:0]  INPUT_CONFIG_FIELD,
  input wire logic [2:0]  CHANNEL_SELECT_FIELD,
  input wire logic [7:0]  CHANNEL_ENABLE,
  input wire logic        FILTER_BANDWIDTH_BIT,
  input wire logic [2:0]  REFERENCE_FIELD,
  input wire logic [1:0]  SEQUENCER_FIELD,
  input wire logic        READBACK_BIT,
  input wire logic        CONVERTING
);
  import adcsc_pkg::*;
  // One domain: all checks on the system clock
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Drive follows selection; idle level while deselected
  property p_select;
    SERIAL_RESULT_OE != CONVERSION_TRIGGER &&
      !(CONVERSION_TRIGGER && SERIAL_RESULT_OUT);
  endproperty
  a_select: assert property (p_select)
    else $error("result line active while deselected");
  // A rise while idle must launch the core
  property p_start_rise;
    $rose(CONVERSION_TRIGGER) && !CONVERTING |-> ##[1:8] CONV_START;
  endproperty
  a_start_rise: assert property (p_start_rise)
    else $error("trigger rise did not start a conversion");
  // Start is a single pulse and never lands mid conversion
  property p_start_once;
    CONV_START |-> !$past(CONVERTING) ##1 !CONV_START;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("bad conversion start pulse");
  // Completion closes the conversion within a few cycles
  property p_done_ends;
    CONV_DONE && CONVERTING |-> ##[1:4] !CONVERTING;
  endproperty
  a_done_ends: assert property (p_done_ends)
    else $error("conversion did not finish after done");
  // Active word only moves right after a completion
  property p_cfg_moment;
    $changed(ACTIVE_CONFIG) |->
      $past(CONV_DONE) || $past(CONV_DONE, 2) || $past(CONV_DONE, 3);
  endproperty
  a_cfg_moment: assert property (p_cfg_moment)
    else $error("active word changed outside conversion end");
  // Field outputs other than the channel select are fixed slices of the active word
  property p_fields;
    {INPUT_CONFIG_FIELD, FILTER_BANDWIDTH_BIT, REFERENCE_FIELD,
     SEQUENCER_FIELD, READBACK_BIT} ==
      {ACTIVE_CONFIG[12:10], ACTIVE_CONFIG[6:0]};
  endproperty
  a_fields: assert property (p_fields)
    else $error("field outputs disagree with active word");
  // Sequencer off: channel is the binary field, one-hot enable
  property p_chan_fixed;
    SEQUENCER_FIELD == 2'h0 |-> CHANNEL_SELECT_FIELD ==
      ACTIVE_CONFIG[9:7] && CHANNEL_ENABLE == 8'h01 << CHANNEL_SELECT_FIELD;
  endproperty
  a_chan_fixed: assert property (p_chan_fixed)
    else $error("channel select wrong with sequencer off");
  // Busy mode puts a zero ahead of the result
  property p_busy_lead;
    $fell(CONVERSION_TRIGGER) && BUSY_INDICATION_MODE |-> !SERIAL_RESULT_OUT;
  endproperty
  a_busy_lead: assert property (p_busy_lead)
    else $error("busy lead bit not zero");
endmodule : adcsc_monitor

bind adcsc_top adcsc_monitor u_monitor (
  .CLK(CLK), .RST(RST), .SERIAL_CLOCK(SERIAL_CLOCK),
  .CONVERSION_TRIGGER(CONVERSION_TRIGGER),
  .SERIAL_CONFIG_IN(SERIAL_CONFIG_IN),
  .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
  .SERIAL_RESULT_OE(SERIAL_RESULT_OE),
  .BUSY_INDICATION_MODE(BUSY_INDICATION_MODE),
  .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
  .CONV_RESULT(CONV_RESULT), .ACTIVE_CONFIG(ACTIVE_CONFIG),
  .INPUT_CONFIG_FIELD(INPUT_CONFIG_FIELD),
  .CHANNEL_SELECT_FIELD(CHANNEL_SELECT_FIELD),
  .CHANNEL_ENABLE(CHANNEL_ENABLE),
  .FILTER_BANDWIDTH_BIT(FILTER_BANDWIDTH_BIT),
  .REFERENCE_FIELD(REFERENCE_FIELD), .SEQUENCER_FIELD(SEQUENCER_FIELD),
  .READBACK_BIT(READBACK_BIT), .CONVERTING(CONVERTING)
);

// [adcsc_host.sv]
// Behavioural serial host: trigger pin, burst clock, setup line
`timescale 1ns/10ps
module adcsc_host (
  output logic     sck,   // Burst clock, rests low
  output logic     trig,  // Trigger pin, low selects
  output logic     din,   // Setup word line
  input wire logic serial_result_out    // Result line from the device
);
  initial begin
    sck = 1'b0;
    trig = 1'b0;  // Low at power-up
    din = 1'b0;
  end
  // Start a conversion, then reselect at once
  task automatic pulse();
    #40;          // Pins quiet before the rise
    trig = 1'b1;
    #60;          // No access while high
    trig = 1'b0;
  endtask : pulse
  // One burst of n cycles at 8 MHz, short enough for any access window
  task automatic frame(input logic [13:0] w, input int n,
                       output logic [31:0] got);
    got = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      din = (i < 14) ? w[13 - i] : ~din;  // MSB first, then junk
      #62.5;
      got[31 - i] = serial_result_out;  // Bit settled since the last fall
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #62.5;
    din = ~din;  // Released line shows no stale level
  endtask : frame
  // Park the setup line at a level
  task automatic set_din(input logic v);
    din = v;
  endtask : set_din
endmodule : adcsc_host

// [adc_serial_config_readout_test.sv]
// Self-checking bench: host model, core stub and reference model
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module adc_serial_config_readout_test;
  import adcsc_pkg::*;
  logic        clk = 1'b0;      // System clock
  logic        rst = 1'b1;      // Reset, held at start
  logic        busy = 1'b0;     // Busy lead bit mode
  logic        done = 1'b0;     // Core completion pulse
  logic [15:0] res = 16'h0000;  // Core result
  wire         sck, trig, din, serial_result_out, start, conv;
  wire  [13:0] act;             // Active setup word
  int          seed = 75, n_mismatch = 0, num_checks = 0;
  int          held = 0, n_conv = 0, n_start = 0;
  // Reference model state
  logic [13:0] m_act = CFG_RESET, m_rbw = CFG_RESET, m_pend, m_start;
  logic [15:0] m_last = RESULT_RESET, m_pub;
  logic        m_pv = 1'b0, m_rben;

  // 250 MHz clock
  always #2 clk = ~clk;
  // Count conversion starts to catch extra ones
  always @(posedge clk) if (start === 1'b1) n_start++;

  adcsc_top dut (
    .CLK(clk), .RST(rst), .SERIAL_CLOCK(sck),
    .CONVERSION_TRIGGER(trig), .SERIAL_CONFIG_IN(din),
    .SERIAL_RESULT_OUT(serial_result_out), .SERIAL_RESULT_OE(),
    .BUSY_INDICATION_MODE(busy), .CONV_START(start),
    .CONV_DONE(done), .CONV_RESULT(res), .ACTIVE_CONFIG(act),
    .INPUT_CONFIG_FIELD(), .CHANNEL_SELECT_FIELD(),
    .CHANNEL_ENABLE(), .FILTER_BANDWIDTH_BIT(), .REFERENCE_FIELD(),
    .SEQUENCER_FIELD(), .READBACK_BIT(), .CONVERTING(conv)
  );
  adcsc_host host (.sck(sck), .trig(trig), .din(din), .serial_result_out(serial_result_out));

  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Wait c edges, then step just past the edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  // One conversion: rise, optional burst, core completion
  task automatic step(input logic [13:0] w, input logic hold,
                      input logic again);
    logic [31:0] r, got, exp;
    int          n, k;
    r = $random(seed);
    busy = r[0];
    held = hold ? held + 1 : 0;
    m_pub = m_last;  // Previous result goes out
    m_rben = ~m_act[READBACK_BIT];
    m_start = m_act;
    if (held >= 2) begin
      m_pend = CFG_DEFAULT;  // Line high over two rises
      m_pv = 1'b1;
    end
    host.pulse();
    n_conv++;
    if (!hold) begin
      n = 17 + busy + (m_rben ? 14 : 0);  // One spare rise past the end
      host.frame(w, n, got);
      exp = {m_pub, m_rben ? m_rbw : 14'h0000, 2'b00} >> busy;
      `CHK("stream", exp, got)
      if (w[UPDATE_BIT]) begin
        m_pend = w;
        m_pv = 1'b1;
      end
    end
    if (again) host.pulse();  // Rise during conversion is ignored
    k = 0;
    while (conv !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    if (k == 50) begin
      n_mismatch++;
      finish_test();
    end
    tick(1);
    res = r[31:16];
    done = 1'b1;
    tick(1);
    done = 1'b0;
    m_last = res;
    m_rbw = m_start;
    if (m_pv) m_act = m_pend;  // Applied only at conversion end
    m_pv = 1'b0;
    tick(6);
    `CHK("config", m_act, act)
    `CHK("starts", n_conv, n_start)
  endtask : step

  // Main sequence; first two steps serve as dummy conversions
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(4);
    `CHK("reset_cfg", CFG_RESET, act)
    for (int i = 0; i < 18; i++) begin
      r = $random(seed);
      if (i % 3 == 0) r[SEQ_MSB:SEQ_LSB] = 2'h0;  // Fixed channel
      if (i % 2 == 1) r[READBACK_BIT] = 1'b0;     // Readback on
      step(r[13:0], 1'b0, i % 4 == 3);
    end
    host.set_din(1'b1);  // Line parked high, no bursts
    repeat (3) step(14'h0000, 1'b1, 1'b0);
    `CHK("default", CFG_DEFAULT, act)
    step(14'h1FFF, 1'b0, 1'b0);  // Flag clear: word dropped
    finish_test();
  end
endmodule : adc_serial_config_readout_test
